/* File: common/scct_pkg.sv */
`default_nettype none
package scct_pkg;
	// ***************************************************************
	// clocking and timing
	// ***************************************************************
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] TICK_MID = 4'h7;

	// ***************************************************************
	// register offsets (byte addresses)
	// ***************************************************************
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TXDATA = 8'h08;
	localparam logic [7:0] OFF_RXDATA = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	// ***************************************************************
	// configuration field layout and update-enable positions
	// ***************************************************************
	localparam int unsigned CFG_W = 9;
	localparam int unsigned UPD_LSB = 16;
	localparam int unsigned UPD_HS = 0;
	localparam int unsigned UPD_BAUD = 1;
	localparam int unsigned UPD_LEN = 2;
	localparam int unsigned UPD_PAR = 3;
	localparam int unsigned UPD_STOP = 4;
	localparam int unsigned UPD_ROLE = 5;

	// baud selector codes
	localparam logic [2:0] BAUD_300 = 3'h0;
	localparam logic [2:0] BAUD_600 = 3'h1;
	localparam logic [2:0] BAUD_1200 = 3'h2;
	localparam logic [2:0] BAUD_2400 = 3'h3;
	localparam logic [2:0] BAUD_4800 = 3'h4;
	localparam logic [2:0] BAUD_9600 = 3'h5;

	// parity codes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;

	// flow-control characters
	localparam logic [7:0] CHR_XON = 8'h11;
	localparam logic [7:0] CHR_XOFF = 8'h13;

	// interrupt bit positions
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_RX = 0;
	localparam int unsigned IRQ_TX = 1;
	localparam int unsigned IRQ_PERR = 2;
	localparam int unsigned IRQ_FERR = 3;
	localparam int unsigned IRQ_OVR = 4;

	typedef struct packed {
		logic role_modem;    // 0 terminal role, 1 modem role
		logic stop2;         // 0 one stop bit, 1 two
		logic [1:0] parity_operand;
		logic len8;          // 0 seven bits, 1 eight bits
		logic [2:0] baud;
		logic flow;          // 0 one-character hardware, 1 xon/xoff
	} scct_cfg_t;

	localparam scct_cfg_t CFG_RESET = '{role_modem: 1'b0, stop2: 1'b1,
		parity_operand: PAR_NONE, len8: 1'b1, baud: BAUD_9600, flow: 1'b0};

	// one bit per rs-232 line, used for inputs, outputs and enables
	typedef struct packed {
		logic txd;
		logic rxd;
		logic dtr;
		logic dsr;
		logic rts;
		logic cts;
	} scct_line_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} scct_fsm_t;

	// 16x tick divisor for a baud selector
	// clk_hz is the clock rate the divisor is reckoned against
	function automatic logic [15:0] scct_div(input logic [2:0] sel, input int unsigned clk_hz);
		int unsigned baud;
		case (sel)
			BAUD_300: baud = 300;
			BAUD_600: baud = 600;
			BAUD_1200: baud = 1200;
			BAUD_2400: baud = 2400;
			BAUD_4800: baud = 4800;
			default: baud = 9600;
		endcase
		return 16'(clk_hz / (OVERSAMPLE * baud));
	endfunction : scct_div

	// parity bit over the active character length
	function automatic logic scct_par(input logic [7:0] d, input logic len8,
		input logic [1:0] mode);
		logic p;
		p = ^{d[7] & len8, d[6:0]};
		return (mode == PAR_ODD) ? ~p : p;
	endfunction : scct_par
endpackage : scct_pkg
`default_nettype wire

/* File: hdl/scct_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module scct_tick (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] divisor,
	output logic tick
);
	import scct_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} scct_tick_st_t;

	scct_tick_st_t s_q;
	scct_tick_st_t s_d;

	// free-running divider; a baud change applies at once, cutting or stretching the period under way
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt >= divisor - 16'h0001) begin
			s_d.cnt = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule : scct_tick
`default_nettype wire

/* File: hdl/scct_uart.sv */
// Contract
// - after reset the channel runs hardware one-character handshake, 9600 baud, 8 bits, no parity, 2 stops.
// - a configuration write selects hardware one-character or xon/xoff flow handshaking.
// - baud rates 300 to 9600 are selectable and bit timing follows the selected rate.
// - character length is 7 or 8 data bits.
// - parity is none, even or odd, generated on transmit and checked on receive.
// - one or two stop bits are sent per character.
// - settings left out of a configuration write keep their current value, which reads back.
// - each link line is driven by only one end.
// - one end is in terminal role and the other in modem role.
// - changing role swaps the direction of each paired line, keeping its meaning.
// - terminal role sends on TxD and receives on RxD; modem role the reverse.
// - hardware mode ignores xon/xoff; flow mode pauses and resumes sending on them.
// - the readiness line is held asserted from reset; no data moves while either is inactive.
// - under hardware handshake each character waits for the far end's permission line.
`timescale 1ns/1ns
`default_nettype none
module scct_uart #(
	// clock rate the baud divisors are reckoned from
	parameter int unsigned CLK_FREQ = scct_pkg::CLK_HZ
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire scct_pkg::scct_line_t line_i,
	output scct_pkg::scct_line_t line_o,
	output scct_pkg::scct_line_t line_oe,
	output logic irq
);
	import scct_pkg::*;

	typedef struct packed {
		scct_cfg_t cfg;
		logic ack;
		logic [31:0] rdata;
		scct_line_t sync1;
		scct_line_t sync2;
		scct_fsm_t tx_st;
		logic [3:0] tx_tick;
		logic [3:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		logic tx_full;
		logic [7:0] tx_hold;
		logic tx_line;
		scct_fsm_t rx_st;
		logic [3:0] rx_tick;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_par;
		logic rx_full;
		logic [7:0] rx_buf;
		logic xoff;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
	} scct_uart_st_t;

	scct_uart_st_t s_q;
	scct_uart_st_t s_d;
	logic tick;
	logic data_in;
	logic peer_ready;
	logic peer_permit;
	logic tx_go;
	logic [3:0] last_bit;
	logic [IRQ_W-1:0] ev;
	logic [7:0] rx_char;
	logic wr_hit;
	logic rd_hit;

	// ***************************************************************
	// 16x oversampling tick at the selected rate
	// ***************************************************************
	scct_tick u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.divisor(scct_div(s_q.cfg.baud, CLK_FREQ)),
		.tick(tick)
	);

	// ***************************************************************
	// link side: role selects which paired line is ours
	// ***************************************************************
	// the received line of each pair is the one the far end drives
	always_comb begin
		data_in = s_q.cfg.role_modem ? s_q.sync2.txd : s_q.sync2.rxd;
		peer_ready = s_q.cfg.role_modem ? s_q.sync2.dtr : s_q.sync2.dsr;
		peer_permit = s_q.cfg.role_modem ? s_q.sync2.rts : s_q.sync2.cts;
	end

	// same meaning on both lines of a pair; only the enable differs by role
	always_comb begin
		line_o.txd = s_q.tx_line;
		line_o.rxd = s_q.tx_line;
		line_o.dtr = 1'b1;
		line_o.dsr = 1'b1;
		line_o.rts = ~s_q.rx_full;
		line_o.cts = ~s_q.rx_full;
		line_oe.txd = ~s_q.cfg.role_modem;
		line_oe.dtr = ~s_q.cfg.role_modem;
		line_oe.rts = ~s_q.cfg.role_modem;
		line_oe.rxd = s_q.cfg.role_modem;
		line_oe.dsr = s_q.cfg.role_modem;
		line_oe.cts = s_q.cfg.role_modem;
	end

	// a character may leave only while both ends are ready
	assign last_bit = s_q.cfg.len8 ? 4'h7 : 4'h6;
	assign tx_go = s_q.tx_full && peer_ready
		&& (s_q.cfg.flow ? ~s_q.xoff : peer_permit);
	assign rx_char = s_q.cfg.len8 ? s_q.rx_sh : {1'b0, s_q.rx_sh[7:1]};

	// ***************************************************************
	// avalon slave: two-cycle access, answer on the second
	// ***************************************************************
	assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
	assign avs_readdata = s_q.rdata;
	assign wr_hit = avs_write & s_q.ack & (avs_byteenable != 4'h0);
	assign rd_hit = avs_read & s_q.ack;
	assign irq = |(s_q.irq_st & s_q.irq_mask);

	// ***************************************************************
	// next-state logic
	// ***************************************************************
	always_comb begin
		s_d = s_q;
		ev = '0;
		// two-stage synchroniser for every pin input
		s_d.sync1 = line_i;
		s_d.sync2 = s_q.sync1;

		// bus handshake and read data capture
		s_d.ack = (avs_read | avs_write) & ~s_q.ack;
		if (avs_read & ~s_q.ack) begin
			case (avs_address)
				OFF_CFG: s_d.rdata = {23'h0, s_q.cfg};
				OFF_STATUS: s_d.rdata = {26'h0, peer_permit, peer_ready,
					s_q.xoff, s_q.rx_full, s_q.tx_full,
					s_q.tx_st != ST_IDLE};
				OFF_RXDATA: s_d.rdata = {24'h0, s_q.rx_buf};
				OFF_IRQ_STAT: s_d.rdata = {27'h0, s_q.irq_st};
				OFF_IRQ_MASK: s_d.rdata = {27'h0, s_q.irq_mask};
				default: s_d.rdata = 32'h0;
			endcase
		end

		// register writes; omitted fields are kept as they are
		if (wr_hit) begin
			case (avs_address)
				OFF_CFG: begin
					if (avs_writedata[UPD_LSB+UPD_HS]) begin
						s_d.cfg.flow = avs_writedata[0];
					end
					if (avs_writedata[UPD_LSB+UPD_BAUD] && avs_writedata[3:1] <= BAUD_9600) begin
						s_d.cfg.baud = avs_writedata[3:1];
					end
					if (avs_writedata[UPD_LSB+UPD_LEN]) begin
						s_d.cfg.len8 = avs_writedata[4];
					end
					if (avs_writedata[UPD_LSB+UPD_PAR] && avs_writedata[6:5] != 2'h3) begin
						s_d.cfg.parity_operand = avs_writedata[6:5];
					end
					if (avs_writedata[UPD_LSB+UPD_STOP]) begin
						s_d.cfg.stop2 = avs_writedata[7];
					end
					if (avs_writedata[UPD_LSB+UPD_ROLE]) begin
						s_d.cfg.role_modem = avs_writedata[8];
					end
				end
				OFF_TXDATA: begin
					// a write while the holding byte is full is dropped
					if (!s_q.tx_full) begin
						s_d.tx_hold = avs_writedata[7:0];
						s_d.tx_full = 1'b1;
					end
				end
				OFF_IRQ_MASK: s_d.irq_mask = avs_writedata[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (rd_hit && avs_address == OFF_RXDATA) begin
			s_d.rx_full = 1'b0;
		end

		// ***************************************************************
		// transmitter
		// ***************************************************************
		if (tick) begin
			case (s_q.tx_st)
				ST_IDLE: begin
					s_d.tx_line = 1'b1;
					if (tx_go) begin
						s_d.tx_st = ST_START;
						s_d.tx_line = 1'b0;
						s_d.tx_sh = s_q.tx_hold;
						s_d.tx_par = scct_par(s_q.tx_hold, s_q.cfg.len8,
							s_q.cfg.parity_operand);
						s_d.tx_full = 1'b0;
						s_d.tx_tick = 4'h0;
						s_d.tx_bit = 4'h0;
					end
				end
				ST_START: begin
					s_d.tx_tick = s_q.tx_tick + 4'h1;
					if (s_q.tx_tick == TICK_LAST) begin
						s_d.tx_st = ST_DATA;
						s_d.tx_line = s_q.tx_sh[0];
					end
				end
				ST_DATA: begin
					s_d.tx_tick = s_q.tx_tick + 4'h1;
					if (s_q.tx_tick == TICK_LAST) begin
						s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
						s_d.tx_bit = s_q.tx_bit + 4'h1;
						s_d.tx_line = s_q.tx_sh[1];
						if (s_q.tx_bit == last_bit) begin
							s_d.tx_bit = 4'h0;
							if (s_q.cfg.parity_operand != PAR_NONE) begin
								s_d.tx_st = ST_PAR;
								s_d.tx_line = s_q.tx_par;
							end else begin
								s_d.tx_st = ST_STOP;
								s_d.tx_line = 1'b1;
							end
						end
					end
				end
				ST_PAR: begin
					s_d.tx_tick = s_q.tx_tick + 4'h1;
					if (s_q.tx_tick == TICK_LAST) begin
						s_d.tx_st = ST_STOP;
						s_d.tx_line = 1'b1;
					end
				end
				ST_STOP: begin
					s_d.tx_tick = s_q.tx_tick + 4'h1;
					if (s_q.tx_tick == TICK_LAST) begin
						// second stop bit only when selected
						if (s_q.cfg.stop2 && s_q.tx_bit == 4'h0) begin
							s_d.tx_bit = 4'h1;
						end else begin
							s_d.tx_st = ST_IDLE;
							ev[IRQ_TX] = 1'b1;
						end
					end
				end
				default: s_d.tx_st = ST_IDLE;
			endcase
		end

		// ***************************************************************
		// receiver, 16x oversampled
		// ***************************************************************
		if (tick) begin
			case (s_q.rx_st)
				ST_IDLE: begin
					if (!data_in) begin
						s_d.rx_st = ST_START;
						s_d.rx_tick = 4'h0;
						s_d.rx_bit = 4'h0;
					end
				end
				ST_START: begin
					s_d.rx_tick = s_q.rx_tick + 4'h1;
					if (s_q.rx_tick == TICK_MID) begin
						// a glitch shorter than half a bit is not a start
						s_d.rx_st = data_in ? ST_IDLE : ST_DATA;
						s_d.rx_tick = 4'h0;
					end
				end
				ST_DATA: begin
					s_d.rx_tick = s_q.rx_tick + 4'h1;
					if (s_q.rx_tick == TICK_LAST) begin
						s_d.rx_sh = {data_in, s_q.rx_sh[7:1]};
						s_d.rx_bit = s_q.rx_bit + 4'h1;
						if (s_q.rx_bit == last_bit) begin
							s_d.rx_st = (s_q.cfg.parity_operand != PAR_NONE)
								? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					s_d.rx_tick = s_q.rx_tick + 4'h1;
					if (s_q.rx_tick == TICK_LAST) begin
						s_d.rx_par = data_in;
						s_d.rx_st = ST_STOP;
					end
				end
				ST_STOP: begin
					s_d.rx_tick = s_q.rx_tick + 4'h1;
					if (s_q.rx_tick == TICK_LAST) begin
						// only the first stop bit is checked
						s_d.rx_st = ST_IDLE;
						ev[IRQ_FERR] = ~data_in;
						ev[IRQ_PERR] = (s_q.cfg.parity_operand != PAR_NONE)
							&& (s_q.rx_par != scct_par(rx_char, s_q.cfg.len8,
							s_q.cfg.parity_operand));
						if (!peer_ready) begin
							// characters arriving without readiness are discarded
						end else if (s_q.cfg.flow && rx_char == CHR_XOFF) begin
							s_d.xoff = 1'b1;
						end else if (s_q.cfg.flow && rx_char == CHR_XON) begin
							s_d.xoff = 1'b0;
						end else if (s_d.rx_full) begin
							ev[IRQ_OVR] = 1'b1;
						end else begin
							s_d.rx_buf = rx_char;
							s_d.rx_full = 1'b1;
							ev[IRQ_RX] = 1'b1;
						end
					end
				end
				default: s_d.rx_st = ST_IDLE;
			endcase
		end
		// leaving flow mode drops any pause in force
		if (!s_d.cfg.flow) begin
			s_d.xoff = 1'b0;
		end

		// ***************************************************************
		// interrupt status: write one to clear, a new event wins
		// ***************************************************************
		if (wr_hit && avs_address == OFF_IRQ_STAT) begin
			s_d.irq_st = s_q.irq_st & ~avs_writedata[IRQ_W-1:0];
		end
		s_d.irq_st = s_d.irq_st | ev;
	end

	// ***************************************************************
	// state register
	// ***************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.cfg <= CFG_RESET;
			s_q.sync1 <= '1;
			s_q.sync2 <= '1;
			s_q.tx_st <= ST_IDLE;
			s_q.rx_st <= ST_IDLE;
			s_q.tx_line <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : scct_uart
`default_nettype wire

/* File: tb/scct_uart_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module scct_uart_asserts #(
	parameter int unsigned CLK_FREQ = scct_pkg::CLK_HZ
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire scct_pkg::scct_line_t line_i,
	input wire scct_pkg::scct_line_t line_o,
	input wire scct_pkg::scct_line_t line_oe,
	input wire logic irq
);
	import scct_pkg::*;
	// shortest legal bit: 16 ticks of the 9600 divider
	localparam int MIN_BIT = int'(OVERSAMPLE * (CLK_FREQ / (OVERSAMPLE * 9600)));
	logic tx_l;
	logic [31:0] run_q;
	logic [31:0] run_d;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// low-run counter on the sending line
	// ****
	// the sending line moves with the role, so follow the enables
	assign tx_l = line_oe.txd ? line_o.txd : line_o.rxd;
	always_comb run_d = tx_l ? 32'h0 : run_q + 32'h1;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 32'h0;
		end else begin
			run_q <= run_d;
		end
	end
	// ****
	// properties
	// ****
	wait_one_a: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("wait not one cycle");
	idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	ready_held_a: assert property (line_o.dtr && line_o.dsr)
		else $error("readiness dropped");
	role_pair_a: assert property (line_oe == 6'h2a || line_oe == 6'h15)
		else $error("line enables not one role");
	role_hold_a: assert property ($changed(line_oe) |->
		$past(avs_write) || $past(avs_write, 2)) else $error("role moved without write");
	bit_time_a: assert property ($rose(tx_l) |-> run_q >= MIN_BIT)
		else $error("low run shorter than a bit");
	permit_pop_a: assert property (avs_read && !avs_waitrequest &&
		avs_address == OFF_RXDATA |-> ##[1:2] (line_o.rts && line_o.cts))
		else $error("permission not back after pop");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
		avs_address > OFF_IRQ_MASK |-> avs_readdata == 32'h0) else $error("unmapped read not 0");
endmodule : scct_uart_asserts
bind scct_uart scct_uart_asserts #(.CLK_FREQ(CLK_FREQ)) chk (.ref_clk, .rst_n, .avs_address,
	.avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .line_i, .line_o,
	.line_oe, .irq);
`default_nettype wire

/* File: tb/scct_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
module scct_far_end #(
	parameter int BIT = 26032
) (
	input wire logic ref_clk,
	input wire logic rx_in,
	input wire logic perm_in,
	output logic data_out,
	output logic ready,
	output logic permit
);
	logic [9:0] got[$];
	logic [9:0] v;
	// ****
	// complementary end, drives only its half of each pair
	// ****
	initial begin
		data_out = 1'b1;
		ready = 1'b1;
		permit = 1'b1;
	end
	// 8 data bits, even parity, one stop: same format as the channel
	task automatic send(input logic [7:0] c);
		logic [10:0] f;
		f = {1'b1, ^c, c, 1'b0};
		wait (perm_in === 1'b1);
		for (int i = 0; i < 11; i++) begin
			data_out <= f[i];
			repeat (BIT) @(posedge ref_clk);
		end
	endtask : send
	// mid-bit sampling, so a wrong bit time shows up as wrong bits
	always begin
		@(negedge rx_in);
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge ref_clk);
			v[i] = rx_in;
		end
		got.push_back(v);
	end
endmodule : scct_far_end
`default_nettype wire

/* File: tb/serial_channel_config_terminal_modem_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
module serial_channel_config_terminal_modem_tb;
	import scct_pkg::*;
	// bit timing scaled down to keep the run short; the 9600 divisor comes out exact
	localparam int unsigned SIM_HZ = 15_360_000;
	localparam int BIT = int'(SIM_HZ / 9600);
	localparam int LIMIT = 80000;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	scct_line_t li;
	scct_line_t lo;
	scct_line_t oe;
	logic fd;
	logic fr;
	logic fp;
	logic fin;
	logic fperm;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] rdv;
	logic [31:0] cfg_m = 32'h9a;
	logic [31:0] mask_m = 32'h0;
	logic [31:0] fm[6] = '{32'h1, 32'he, 32'h10, 32'h60, 32'h80, 32'h100};
	logic [31:0] wl[4] = '{32'h000a01df, 32'h00010001, 32'h00040000, 32'h003f013a};
	logic [7:0] c;
	logic [7:0] c2;
	// ****
	// wiring: each line level comes from whichever end enables it
	// ****
	assign li = {oe.txd ? lo.txd : fd, oe.rxd ? lo.rxd : fd, oe.dtr ? lo.dtr : fr,
		oe.dsr ? lo.dsr : fr, oe.rts ? lo.rts : fp, oe.cts ? lo.cts : fp};
	assign fin = oe.txd ? li.txd : li.rxd;
	assign fperm = oe.rts ? lo.rts : lo.cts;
	scct_uart #(.CLK_FREQ(SIM_HZ)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .line_i(li), .line_o(lo), .line_oe(oe), .irq(irq));
	scct_far_end #(.BIT(BIT)) far (.ref_clk(ref_clk), .rx_in(fin), .perm_in(fperm), .data_out(fd),
		.ready(fr), .permit(fp));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// ****
	// bus tasks and reference model
	// ****
	// one transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rdv, e)
	endtask : rchk
	// a field moves only when its update enable is set
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		for (int i = 0; i < 6; i++) begin
			// baud codes above 9600 and parity code 3 are refused
			if (a == OFF_CFG && d[UPD_LSB + i] && !(i == UPD_BAUD && d[3:1] > BAUD_9600)
				&& !(i == UPD_PAR && d[6:5] == 2'h3)) cfg_m = (cfg_m & ~fm[i]) | (d & fm[i]);
		end
		if (a == OFF_IRQ_MASK) mask_m = d & 32'h1f;
	endtask : wr
	task automatic finish_test;
		if (errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	// hang guard: a frame each way fits well inside the ceiling
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			errors++;
			finish_test();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(47168));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		`CHK(oe, 6'h2a)
		rchk(OFF_CFG, 32'h9a);
		foreach (wl[i]) begin
			wr(OFF_CFG, wl[i]);
			rchk(OFF_CFG, cfg_m);
		end
		wr(OFF_IRQ_MASK, 32'h1);
		rchk(OFF_IRQ_MASK, mask_m);
		rchk(8'h18, 32'h0);
		`CHK(oe, 6'h15)
		c = 8'($urandom);
		c2 = 8'($urandom);
		// far end withholds permission: the character must wait
		far.permit <= 1'b0;
		wr(OFF_TXDATA, {24'h0, c});
		repeat (8000) @(posedge ref_clk);
		`CHK(lo.rxd, 1'b1)
		fork
			far.send(c2);
			begin
				far.permit <= 1'b1;
				while (far.got.size() == 0) @(posedge ref_clk);
			end
		join
		repeat (BIT) @(posedge ref_clk);
		`CHK(far.got[0], {1'b1, ^c, c})
		`CHK(irq, 1'b1)
		rchk(OFF_IRQ_STAT, 32'h3);
		`CHK(lo.cts, 1'b0)
		rchk(OFF_RXDATA, {24'h0, c2});
		repeat (2) @(posedge ref_clk);
		`CHK(lo.cts, 1'b1)
		wr(OFF_IRQ_STAT, 32'h1);
		@(posedge ref_clk);
		`CHK(irq, 1'b0)
		rchk(OFF_IRQ_STAT, 32'h2);
		wr(OFF_IRQ_MASK, 32'h2);
		@(posedge ref_clk);
		`CHK(irq, 1'b1)
		wr(OFF_IRQ_MASK, 32'h0);
		@(posedge ref_clk);
		`CHK(irq, 1'b0)
		// flow mode: a received pause character is consumed, not stored
		wr(OFF_CFG, 32'h00010001);
		far.send(CHR_XOFF);
		rchk(OFF_STATUS, 32'h38);
		rchk(OFF_IRQ_STAT, 32'h2);
		wr(OFF_CFG, 32'h00010000);
		rchk(OFF_STATUS, 32'h30);
		rchk(OFF_CFG, cfg_m);
		finish_test();
	end
endmodule : serial_channel_config_terminal_modem_tb
`default_nettype wire
